/* File: logic/ssv_sync_vcm_top.sv */
// Purpose: Serial register bank for software sync and common-mode buffer set-up.
// Assumes: sclk at most mclk/16; serial mode with sdi taken on sclk rising edge.
// Notes:   Frame is rw bit (1 = read), 7-bit address, 8-bit data, msb first.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Power-down bit set turns common-mode buffer off; clear keeps it running.
// - Two-bit select picks half supply, 1.65 V, 2.5 V or 2.14 V.
// - Channel 0 standby also disables the common-mode output.
// - Request is taken at last rising sclk of the frame raising the bit.
// - Software request acts like a start pulse and appears on sync output.
// - Each pulse seen on sync input resets all decimation filters.
// - After a sync reset, data stays withheld until filters have settled.
// - The software sync bit resets to one.
// - Retime bit set derives the sync output from the opposite mclk edge.
module ssv_sync_vcm_top #(
  parameter int unsigned SETTLE_CYCLES = ssv_pkg::SETTLE_CYCLES_DEF,
  parameter int unsigned CNT_W         = 16
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset,
  // Serial register port.
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // Sync pins.
  input  wire logic       start_n,
  input  wire logic       sync_in_n,
  output logic            sync_out_n,
  // Channel and analog control.
  input  wire logic       ch0_standby,
  output logic            cm_buffer_powerdown,
  output logic            cm_output_enable,
  output logic [1:0]      cm_voltage_select,
  // Filter and data control.
  output logic            filter_reset,
  output logic            data_output_enable
);
  localparam logic [2:0]       PULSE_LEN  =
    3'(ssv_pkg::SYNC_PULSE_CYCLES);
  localparam logic [CNT_W-1:0] SETTLE_LEN = CNT_W'(SETTLE_CYCLES);

  logic [3:0] pins;
  logic [3:0] lv;
  logic       sclk_s;
  logic       cs_n_s;
  logic       sdi_s;
  logic       start_n_s;

  assign pins = {sclk, cs_n, sdi, start_n};

  ssv_pin_sync #(
    .WIDTH (4),
    // Reset levels match the idle pins, so no false start edge follows reset.
    .INIT  (4'h5)
  ) u_pins (
    .mclk      (mclk),
    .reset     (reset),
    .pin_in    (pins),
    .level_out (lv)
  );

  assign sclk_s    = lv[3];
  assign cs_n_s    = lv[2];
  assign sdi_s     = lv[1];
  assign start_n_s = lv[0];

  logic sync_in_s;

  ssv_pin_sync #(
    .WIDTH (1),
    .INIT  (1'h1)
  ) u_sync_in (
    .mclk      (mclk),
    .reset     (reset),
    .pin_in    (sync_in_n),
    .level_out (sync_in_s)
  );

  // Serial frame state.
  logic        sclk_d_r,   sclk_d_nxt;
  logic        start_d_r,  start_d_nxt;
  logic [4:0]  bit_cnt_r,  bit_cnt_nxt;
  logic [15:0] shift_r,    shift_nxt;
  logic [7:0]  tx_r,       tx_nxt;
  logic        sdo_r,      sdo_nxt;
  // Registers.
  logic [7:0]  gen_cfg_r,  gen_cfg_nxt;
  logic        ssync_r,    ssync_nxt;
  // Sync output and filter settling.
  logic [2:0]  pulse_cnt_r, pulse_cnt_nxt;
  logic        sync_pos_r,  sync_pos_nxt;
  logic        sync_neg_r;
  logic        sync_in_d_r, sync_in_d_nxt;
  logic        frst_r,      frst_nxt;
  logic [CNT_W-1:0] settle_cnt_r, settle_cnt_nxt;
  ssv_pkg::ssv_settle_t st_r, st_nxt;
  logic        cm_en_r,     cm_en_nxt;

  logic        sclk_rise;
  logic        sclk_fall;
  logic [15:0] frame;
  logic [7:0]  rdata;
  logic        wr_done;
  logic        soft_req;

  always_comb begin
    sclk_rise   = sclk_s & ~sclk_d_r & ~cs_n_s;
    sclk_fall   = ~sclk_s & sclk_d_r & ~cs_n_s;
    sclk_d_nxt  = sclk_s;
    start_d_nxt = start_n_s;
    frame       = {shift_r[14:0], sdi_s};
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    tx_nxt      = tx_r;
    sdo_nxt     = sdo_r;
    wr_done     = 1'b0;
    // Read data is picked at the address's last bit, while the address
    // still sits in the low bits of the frame.
    case (frame[ssv_pkg::ADDR_W-1:0])
      ssv_pkg::GEN_CFG_ADDR:   rdata = gen_cfg_r;
      ssv_pkg::DATA_CTRL_ADDR: rdata = {ssync_r, 7'h00};
      default:                 rdata = ssv_pkg::UNMAPPED_READ;
    endcase
    if (cs_n_s) begin
      bit_cnt_nxt = 5'h00;
      sdo_nxt     = 1'b0;
    end else if (sclk_rise && bit_cnt_r < 5'(ssv_pkg::FRAME_BITS)) begin
      shift_nxt   = frame;
      bit_cnt_nxt = bit_cnt_r + 5'h01;
      if (bit_cnt_r == 5'(ssv_pkg::ADDR_W)) begin
        tx_nxt = rdata;
      end
      // The write acts on the frame's last rising sclk edge.
      if (bit_cnt_r == 5'(ssv_pkg::FRAME_BITS - 1) && !frame[15]) begin
        wr_done = 1'b1;
      end
    end else if (sclk_fall && bit_cnt_r >= 5'(ssv_pkg::DATA_W)) begin
      sdo_nxt = tx_r[7];
      tx_nxt  = {tx_r[6:0], 1'b0};
    end
  end

  always_comb begin
    gen_cfg_nxt = gen_cfg_r;
    ssync_nxt   = ssync_r;
    soft_req    = 1'b0;
    if (wr_done && frame[14:8] == ssv_pkg::GEN_CFG_ADDR) begin
      gen_cfg_nxt = frame[7:0];
    end
    if (wr_done && frame[14:8] == ssv_pkg::DATA_CTRL_ADDR) begin
      ssync_nxt = frame[ssv_pkg::SOFT_SYNC_BIT];
      // Only a low-to-high change of the bit requests a sync.
      soft_req  = ~ssync_r & frame[ssv_pkg::SOFT_SYNC_BIT];
    end
  end

  // A soft request or a start pin falling edge both launch the pulse.
  always_comb begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (soft_req || (start_d_r && !start_n_s)) begin
      pulse_cnt_nxt = PULSE_LEN;
    end else if (pulse_cnt_r != 3'h0) begin
      pulse_cnt_nxt = pulse_cnt_r - 3'h1;
    end
    sync_pos_nxt = (pulse_cnt_nxt != 3'h0);
  end

  // Every falling edge on the sync input resets the filters and
  // restarts the settling wait, even one arriving mid-settle.
  always_comb begin
    sync_in_d_nxt  = sync_in_s;
    frst_nxt       = sync_in_d_r & ~sync_in_s;
    st_nxt         = st_r;
    settle_cnt_nxt = settle_cnt_r;
    if (frst_r) begin
      st_nxt         = ssv_pkg::SSV_SETTLE;
      settle_cnt_nxt = SETTLE_LEN;
    end else begin
      case (st_r)
        ssv_pkg::SSV_RUN: begin
          settle_cnt_nxt = '0;
        end
        ssv_pkg::SSV_SETTLE: begin
          if (settle_cnt_r <= CNT_W'(1)) begin
            st_nxt         = ssv_pkg::SSV_RUN;
            settle_cnt_nxt = '0;
          end else begin
            settle_cnt_nxt = settle_cnt_r - CNT_W'(1);
          end
        end
        default: begin
          st_nxt = ssv_pkg::SSV_RUN;
        end
      endcase
    end
    // The common-mode output hangs off channel 0, so its standby kills it.
    cm_en_nxt = ~gen_cfg_r[ssv_pkg::CM_PD_BIT] & ~ch0_standby;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sclk_d_r     <= 1'b0;
      start_d_r    <= 1'b1;
      bit_cnt_r    <= 5'h00;
      shift_r      <= 16'h0000;
      tx_r         <= 8'h00;
      sdo_r        <= 1'b0;
      gen_cfg_r    <= ssv_pkg::GEN_CFG_RST;
      ssync_r      <= ssv_pkg::DATA_CTRL_RST[ssv_pkg::SOFT_SYNC_BIT];
      pulse_cnt_r  <= 3'h0;
      sync_pos_r   <= 1'b0;
      sync_in_d_r  <= 1'b1;
      frst_r       <= 1'b0;
      st_r         <= ssv_pkg::SSV_RUN;
      settle_cnt_r <= '0;
      cm_en_r      <= 1'b0;
    end else begin
      sclk_d_r     <= sclk_d_nxt;
      start_d_r    <= start_d_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      shift_r      <= shift_nxt;
      tx_r         <= tx_nxt;
      sdo_r        <= sdo_nxt;
      gen_cfg_r    <= gen_cfg_nxt;
      ssync_r      <= ssync_nxt;
      pulse_cnt_r  <= pulse_cnt_nxt;
      sync_pos_r   <= sync_pos_nxt;
      sync_in_d_r  <= sync_in_d_nxt;
      frst_r       <= frst_nxt;
      st_r         <= st_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      cm_en_r      <= cm_en_nxt;
    end
  end

  // Half-cycle retimed copy of the pulse for the alternate edge option.
  always_ff @(negedge mclk) begin
    if (reset) begin
      sync_neg_r <= 1'b0;
    end else begin
      sync_neg_r <= sync_pos_r;
    end
  end

  assign sync_out_n = gen_cfg_r[ssv_pkg::RETIME_BIT] ? ~sync_neg_r
                                                     : ~sync_pos_r;
  assign sdo                 = sdo_r;
  assign sdo_oe              = ~cs_n_s;
  assign cm_buffer_powerdown = gen_cfg_r[ssv_pkg::CM_PD_BIT];
  assign cm_voltage_select   = gen_cfg_r[ssv_pkg::CM_VSEL_LSB +: 2];
  assign cm_output_enable    = cm_en_r;
  assign filter_reset        = frst_r;
  assign data_output_enable  = (st_r == ssv_pkg::SSV_RUN);
endmodule : ssv_sync_vcm_top
`default_nettype wire

/* File: logic/ssv_pkg.sv */
// Purpose: Shared constants for the software sync and common-mode config bank.
// Assumes: 40 MHz mclk; 16-bit serial frames (rw, 7-bit address, 8-bit data).
// Notes:   The sync pulse time is kept in nanoseconds and turned into cycles here.
package ssv_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned FRAME_BITS    = 16;

  // Register offsets and reset values.
  localparam logic [6:0] GEN_CFG_ADDR   = 7'h05;
  localparam logic [6:0] DATA_CTRL_ADDR = 7'h06;
  localparam logic [7:0] GEN_CFG_RST    = 8'h08;
  localparam logic [7:0] DATA_CTRL_RST  = 8'h80;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // Field positions.
  localparam int unsigned RETIME_BIT    = 5;
  localparam int unsigned CM_PD_BIT     = 4;
  localparam int unsigned CM_VSEL_LSB   = 0;
  localparam int unsigned SOFT_SYNC_BIT = 7;

  // Common-mode output level codes.
  localparam logic [1:0] CM_HALF_SUPPLY = 2'h0;
  localparam logic [1:0] CM_1V65        = 2'h1;
  localparam logic [1:0] CM_2V50        = 2'h2;
  localparam logic [1:0] CM_2V14        = 2'h3;

  // Sync output pulse: least time, rounded up to whole cycles.
  localparam int unsigned SYNC_PULSE_NS     = 100;
  localparam int unsigned SYNC_PULSE_CYCLES =
    (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default filter settling time in mclk cycles.
  localparam int unsigned SETTLE_CYCLES_DEF = 8192;

  typedef enum logic [0:0] {
    SSV_RUN    = 1'b0,
    SSV_SETTLE = 1'b1
  } ssv_settle_t;
endpackage : ssv_pkg

/* File: logic/ssv_pin_sync.sv */
// Purpose: Three-flop synchroniser with agreement filter for a group of pins.
// Assumes: Inputs are asynchronous to mclk.
// Notes:   A new level is accepted only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ssv_pin_sync #(
  parameter int unsigned         WIDTH = 1,
  parameter logic [WIDTH-1:0]    INIT  = '0
) (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              reset,
  // Pins and clean levels.
  input  wire logic [WIDTH-1:0]  pin_in,
  output logic      [WIDTH-1:0]  level_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;
  logic [WIDTH-1:0] lvl_nxt;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_r  <= INIT;
      s2_r  <= INIT;
      s3_r  <= INIT;
      lvl_r <= INIT;
    end else begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule : ssv_pin_sync
`default_nettype wire

/* File: sim/ssv_sync_vcm_checker.sv */
// Purpose: Port checks for the sync and common-mode bank.
// Assumes: Single mclk domain with synchronous reset.
// Notes:   Bound into ssv_sync_vcm_top.
`timescale 1ns/1ps
`default_nettype none
module ssv_sync_vcm_checker #(
  parameter int unsigned SETTLE_CYCLES = ssv_pkg::SETTLE_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic       mclk,
  input wire logic       reset,
  // Pins.
  input wire logic       cs_n,
  input wire logic       sdo_oe,
  input wire logic       start_n,
  input wire logic       sync_in_n,
  input wire logic       sync_out_n,
  input wire logic       ch0_standby,
  // Outputs under watch.
  input wire logic       cm_buffer_powerdown,
  input wire logic       cm_output_enable,
  input wire logic [1:0] cm_voltage_select,
  input wire logic       filter_reset,
  input wire logic       data_output_enable
);
  logic [15:0] low_cnt_r;
  logic [15:0] low_cnt_nxt;
  always_comb begin
    low_cnt_nxt = (filter_reset || data_output_enable) ? 16'h0 :
                  low_cnt_r + 16'h1;
  end
  always_ff @(posedge mclk) begin
    low_cnt_r <= reset ? 16'h0 : low_cnt_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_pulse_width: assert property (
    $fell(sync_out_n) |=> !sync_out_n [*3] ##1 sync_out_n)
    else $error("sync output pulse width wrong");
  chk_start_to_sync: assert property (
    $fell(start_n) |-> ##[2:10] !sync_out_n)
    else $error("start pin gave no sync output");
  chk_sync_to_filter: assert property (
    $fell(sync_in_n) |-> ##[2:8] filter_reset)
    else $error("sync input gave no filter reset");
  chk_filter_single: assert property (
    filter_reset |=> !filter_reset)
    else $error("filter reset longer than one cycle");
  chk_settle_hold: assert property (
    filter_reset |=> !data_output_enable)
    else $error("data not withheld after filter reset");
  chk_settle_length: assert property (
    $rose(data_output_enable) |-> low_cnt_r == 16'(SETTLE_CYCLES))
    else $error("settle time wrong");
  chk_cm_disable: assert property (
    (cm_buffer_powerdown || ch0_standby) |=> !cm_output_enable)
    else $error("common-mode output not disabled");
  chk_cm_stable: assert property (
    cs_n [*8] |=> $stable(cm_voltage_select) && $stable(cm_buffer_powerdown))
    else $error("common-mode fields changed without a frame");
  chk_sdo_release: assert property (
    cs_n [*5] |-> !sdo_oe)
    else $error("serial output driven while deselected");
  chk_sdo_drive: assert property (
    !cs_n [*5] |-> sdo_oe)
    else $error("serial output not driven while selected");
  cover property ($fell(sync_out_n));
  cover property ($rose(data_output_enable));
  cover property (ch0_standby && !cm_buffer_powerdown);
endmodule : ssv_sync_vcm_checker
bind ssv_sync_vcm_top ssv_sync_vcm_checker #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (
  .mclk(mclk), .reset(reset), .cs_n(cs_n), .start_n(start_n),
  .sdo_oe(sdo_oe),
  .sync_in_n(sync_in_n), .sync_out_n(sync_out_n),
  .ch0_standby(ch0_standby), .cm_buffer_powerdown(cm_buffer_powerdown),
  .cm_output_enable(cm_output_enable),
  .cm_voltage_select(cm_voltage_select), .filter_reset(filter_reset),
  .data_output_enable(data_output_enable));
`default_nettype wire

/* File: sim/ssv_host_model.sv */
// Purpose: Serial host that sends frames and captures read data.
// Assumes: Frame is rw, 7-bit address, 8-bit data, msb first.
// Notes:   Each sclk phase lasts 8 mclk, above the synchroniser delay.
`timescale 1ns/1ps
`default_nettype none
module ssv_host_model (
  // Clock.
  input  wire logic      mclk,
  // Serial pins.
  input  wire logic      sdo,
  output var  logic      sclk,
  output var  logic      cs_n,
  output var  logic      sdi,
  // Captured read data.
  output var  logic [7:0] rd_data,
  output var  logic      rd_done
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    rd_data = 8'h00;
    rd_done = 1'b0;
  end
  task automatic xfer(input logic [15:0] frame);
    cs_n <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int i = 15; i >= 0; i--) begin
      sdi <= frame[i];
      repeat (8) @(posedge mclk);
      if (i < 8) rd_data[i] <= sdo;
      sclk <= 1'b1;
      repeat (8) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    cs_n <= 1'b1;
    // A released data line must not look like a held bit.
    sdi <= ~frame[0];
    rd_done <= frame[15];
    @(posedge mclk);
    rd_done <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : xfer
endmodule : ssv_host_model
`default_nettype wire

/* File: sim/test_software_sync_and_vcm_config.sv */
// Purpose: Self-checking bench for the sync and common-mode bank.
// Assumes: Host model drives the serial port; sync output loops to input.
// Notes:   Settle time is shortened to 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_software_sync_and_vcm_config;
  localparam int unsigned SETTLE = 16;
  logic       mclk;
  logic       reset;
  logic       sclk;
  logic       cs_n;
  logic       sdi;
  logic       sdo;
  logic       start_n;
  logic       sync_out_n;
  logic       ch0_standby;
  logic       cm_pd;
  logic       cm_oe;
  logic [1:0] cm_vsel;
  logic       filter_reset;
  logic       doe;
  logic [7:0] rd_data;
  logic       rd_done;
  logic [7:0] v;
  logic       sb;
  logic [7:0] rd_q[$];
  logic       edge_q[$];
  int         fail_count;
  int         samples_checked;
  int         cycles;
  int         fr_seen;
  int         low_n;
  ssv_sync_vcm_top #(.SETTLE_CYCLES(SETTLE)) dut (
    .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(), .start_n(start_n),
    .sync_in_n(sync_out_n),
    .sync_out_n(sync_out_n), .ch0_standby(ch0_standby),
    .cm_buffer_powerdown(cm_pd), .cm_output_enable(cm_oe),
    .cm_voltage_select(cm_vsel), .filter_reset(filter_reset),
    .data_output_enable(doe));
  ssv_host_model host (.mclk(mclk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .rd_data(rd_data), .rd_done(rd_done));
  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b0, a, d});
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    host.xfer({1'b1, a, 8'h00});
  endtask : rd
  task automatic soft_sync(input logic rt);
    wr(ssv_pkg::GEN_CFG_ADDR, 8'(rt) << ssv_pkg::RETIME_BIT);
    wr(ssv_pkg::DATA_CTRL_ADDR, 8'h00);
    edge_q.push_back(!rt);
    wr(ssv_pkg::DATA_CTRL_ADDR, 8'h80);
    repeat (40) @(posedge mclk);
  endtask : soft_sync
  task automatic report_and_stop();
    $display("checked %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // About 21 frames of 281 cycles each; the ceiling leaves wide margin.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  always @(posedge mclk) begin
    if (rd_done === 1'b1) begin
      if (rd_q.size() == 0) cmp("read count", 8'h00, 8'h01);
      else cmp("read data", rd_q.pop_front(), rd_data);
    end
    if (filter_reset === 1'b1) fr_seen++;
    if (doe === 1'b0) low_n++;
    else if (low_n != 0) begin
      cmp("settle cycles", 8'(SETTLE), 8'(low_n));
      low_n = 0;
    end
  end
  always @(negedge sync_out_n) begin
    if (edge_q.size() == 0) cmp("sync pulse", 8'h00, 8'h01);
    else cmp("sync edge", 8'(edge_q.pop_front()), 8'(mclk));
  end
  initial begin
    reset = 1'b1;
    start_n = 1'b1;
    ch0_standby = 1'b0;
    void'($urandom(94955));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(ssv_pkg::GEN_CFG_ADDR, 8'h08);
    rd(ssv_pkg::DATA_CTRL_ADDR, 8'h80);
    rd(7'h10, 8'h00);
    cmp("cm pd", 8'h00, 8'(cm_pd));
    cmp("sync out", 8'h01, 8'(sync_out_n));
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = {6'($urandom), 2'(i)};
      sb = 1'($urandom);
      ch0_standby <= sb;
      wr(ssv_pkg::GEN_CFG_ADDR, v);
      rd(ssv_pkg::GEN_CFG_ADDR, v);
      cmp("cm vsel", 8'(i), 8'(cm_vsel));
      cmp("cm pd", 8'(v[4]), 8'(cm_pd));
      cmp("cm en", 8'(!v[4] && !sb), 8'(cm_oe));
    end
    ch0_standby <= 1'b0;
    $display("test level fields done");
    soft_sync(1'b0);
    soft_sync(1'b0);
    soft_sync(1'b1);
    wr(ssv_pkg::DATA_CTRL_ADDR, 8'h80);
    $display("test soft sync done");
    // Retime is still set, so the start pulse leaves on the falling edge.
    edge_q.push_back(1'b0);
    start_n <= 1'b0;
    repeat (8) @(posedge mclk);
    start_n <= 1'b1;
    repeat (60) @(posedge mclk);
    cmp("filter resets", 8'h04, 8'(fr_seen));
    cmp("pulses left", 8'h00, 8'(edge_q.size()));
    $display("test start pin done");
    report_and_stop();
  end
endmodule : test_software_sync_and_vcm_config
`default_nettype wire
